// *** logic/trigger_flow_params.svh ***
`ifndef TRIGGER_FLOW_PARAMS_SVH
`define TRIGGER_FLOW_PARAMS_SVH

// APB register offsets (byte addresses)
`define TF_REG_CTRL      12'h000
`define TF_REG_LEVELS    12'h004
`define TF_REG_ENABLE    12'h008
`define TF_REG_STATUS    12'h00c
`define TF_REG_LVLCFG0   12'h040
`define TF_REG_LVLSTEP   12'h004

// Control register fields
`define TF_CTRL_MODE     0
`define TF_CTRL_SEGM     1
`define TF_CTRL_EXTEN    2
`define TF_CTRL_ARM      3

// Level configuration fields
`define TF_LVL_MASK_LSB  0
`define TF_LVL_VAL_LSB   8
`define TF_LVL_TYPE_LSB  16
`define TF_LVL_OP_LSB    18

// Sizes and counts
`define TF_MAX_LEVELS    10
`define TF_SKIP_COUNT    2'h3
`define TF_PROBE_W       8
`define TF_FIFO_DEPTH    4

// Reset values
`define TF_CTRL_RST      4'h0
`define TF_LEVELS_RST    4'h1
`define TF_ENABLE_RST    10'h3ff

`endif

// *** logic/trigger_flow_pkg.sv ***
package trigger_flow_pkg;

    typedef enum logic [1:0] {
        CondBasic,
        CondCompare,
        CondAdvanced
    } cond_type_e;

    typedef enum logic [1:0] {
        FirstFlowState,
        SecondFlowState,
        FlowDone
    } flow_state_e;

    typedef struct packed {
        logic [1:0] op;
        logic [1:0] kind;
        logic [7:0] value;
        logic [7:0] mask;
    } level_cfg_s;

    typedef struct packed {
        logic       trigger;
        logic       storeEn;
        logic [7:0] sample;
    } capture_s;

endpackage : trigger_flow_pkg

// *** logic/sample_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } fifo_state_s;

    fifo_state_s     s_q;
    fifo_state_s     s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic            push;
    logic            pop;

    assign inReady  = (s_q.count != (AW+1)'(DEPTH));
    assign outValid = (s_q.count != '0);
    assign outData  = mem[s_q.rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.wrPtr = (s_q.wrPtr == AW'(DEPTH - 1)) ? '0 : s_q.wrPtr + 1'b1;
        end
        if (pop)
        begin
            s_d.rdPtr = (s_q.rdPtr == AW'(DEPTH - 1)) ? '0 : s_q.rdPtr + 1'b1;
        end
        case ({push, pop})
            2'b10:   s_d.count = s_q.count + 1'b1;
            2'b01:   s_d.count = s_q.count - 1'b1;
            default: s_d.count = s_q.count;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
        if (push)
        begin
            mem[s_q.wrPtr] <= inData;
        end
    end

endmodule : sample_fifo

`default_nettype wire

// *** logic/trigger_flow_sequencer.sv ***
// Behaviour
// - Two flow modes: sequential cascade by default, or state-based flow.
// - Sequential mode checks levels in order, up to ten levels.
// - Final trigger fires when last level hits after all earlier ones.
// - Segmented buffer: later segments start on the last level alone.
// - External trigger acts as level zero, required before any level; the state-based flow here ignores it.
// - Both flows work with segmented and non-segmented buffers.
// - Each level has an enable; disabled levels are skipped.
// - Each level is basic, compare or advanced; types may be mixed.
// - State-based mode runs a state machine choosing states and actions.
// - Skip flow: store, stop on condition one, count to three, trigger.
// - Capture only completes once storage is enabled after the trigger.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "trigger_flow_params.svh"

module trigger_flow_sequencer (
    // Clock and restart reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Probed design signals and external trigger pin
    input  wire logic [7:0]  probeData,
    input  wire logic        extTrigIn,
    // Capture buffer side
    output logic             capValid,
    input  wire logic        capReady,
    output logic [7:0]       capSample,
    output logic             capStoreEn,
    output logic             capTrigger,
    output logic             segmentStart
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0]                      prdata;
        logic                             pready;
        logic                             pslverr;
        logic [3:0]                       ctrl;
        logic [3:0]                       levels;
        logic [9:0]                       enable;
        trigger_flow_pkg::level_cfg_s [9:0] cfg;
        logic [3:0]                       levelPtr;
        logic                             extSeen;
        logic                             firstDone;
        logic                             triggered;
        trigger_flow_pkg::flow_state_e    flowState;
        logic [1:0]                       skipCycleCounter;
        logic                             storeOn;
        logic [2:0]                       extSync;
        logic                             extLevel;
        logic [7:0]                       prevProbe;
        logic                             segPulse;
        logic                             capValid;
        logic                             capStoreEn;
        logic                             capTrigger;
        logic [7:0]                       capSample;
        logic                             trigOut;
    } seq_state_s;
    seq_state_s s_q;
    seq_state_s s_d;
    logic                       fifoOutValid;
    trigger_flow_pkg::capture_s fifoIn;
    trigger_flow_pkg::capture_s fifoOut;

    // ************************************************************
    // Condition evaluation
    // ************************************************************
    // Basic is masked equality; compare and advanced follow the op field
    function automatic logic condHit(
        input trigger_flow_pkg::level_cfg_s c,
        input logic [7:0]                   d,
        input logic [7:0]                   prev
    );
        logic [7:0] md;
        md = d & c.mask;
        condHit = 1'b0;
        case (c.kind)
            trigger_flow_pkg::CondBasic: condHit = (md == (c.value & c.mask));
            trigger_flow_pkg::CondCompare:
                case (c.op)
                    2'h0:    condHit = (md == c.value);
                    2'h1:    condHit = (md > c.value);
                    2'h2:    condHit = (md < c.value);
                    default: condHit = (md != c.value);
                endcase
            trigger_flow_pkg::CondAdvanced:
                case (c.op)
                    2'h0:    condHit = (md == c.mask) && (c.mask != 8'h00);
                    2'h1:    condHit = (md != 8'h00);
                    2'h2:    condHit = ^md;
                    default: condHit = ((d ^ prev) & c.mask) != 8'h00;
                endcase
            default: condHit = 1'b0;
        endcase
    endfunction : condHit

    // Index of the last enabled level below the configured count
    function automatic logic [3:0] lastLevel(
        input logic [3:0] n,
        input logic [9:0] en
    );
        lastLevel = 4'hf;
        for (int i = 0; i < `TF_MAX_LEVELS; i++)
            if ((4'(i) < n) && en[i])
                lastLevel = 4'(i);
    endfunction : lastLevel

    logic [3:0] lastIdx;
    logic       lvlHit;
    logic       lastHit;
    logic [3:0] widx;
    logic       apbAcc;
    logic       cfgOk;

    always_comb
    begin
        lastIdx = lastLevel(s_q.levels, s_q.enable);
        lvlHit  = (s_q.levelPtr < 4'(`TF_MAX_LEVELS))
                  ? condHit(s_q.cfg[s_q.levelPtr], probeData, s_q.prevProbe)
                  : 1'b0;
        lastHit = (lastIdx < 4'(`TF_MAX_LEVELS))
                  ? condHit(s_q.cfg[lastIdx], probeData, s_q.prevProbe)
                  : 1'b0;
        widx    = 4'((paddr - `TF_REG_LVLCFG0) >> 2);
        apbAcc  = psel & penable & ~s_q.pready;
        cfgOk   = (paddr >= `TF_REG_LVLCFG0) && (paddr[1:0] == 2'b00)
                  && (paddr < `TF_REG_LVLCFG0 + 12'(4 * `TF_MAX_LEVELS));
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d            = s_q;
        s_d.pready     = 1'b0;
        s_d.pslverr    = 1'b0;
        s_d.segPulse   = 1'b0;
        s_d.trigOut    = 1'b0;
        s_d.prevProbe  = probeData;
        s_d.extSync    = {s_q.extSync[1:0], extTrigIn};
        if (s_q.extSync[2] == s_q.extSync[1])
            s_d.extLevel = s_q.extSync[1];

        // APB: one wait state, answer in the second access cycle after setup
        if (apbAcc)
        begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            if (pwrite)
            begin
                case (paddr)
                    `TF_REG_CTRL:   s_d.ctrl   = pwdata[3:0];
                    `TF_REG_LEVELS: s_d.levels =
                        (pwdata[3:0] > 4'(`TF_MAX_LEVELS))
                        ? 4'(`TF_MAX_LEVELS) : pwdata[3:0];
                    `TF_REG_ENABLE: s_d.enable = pwdata[9:0];
                    `TF_REG_STATUS: s_d.pslverr = 1'b1;
                    default:
                        if (cfgOk)
                            s_d.cfg[widx] = pwdata[19:0];
                        else
                            s_d.pslverr = 1'b1;
                endcase
            end
            else
            begin
                case (paddr)
                    `TF_REG_CTRL:   s_d.prdata = {28'h0, s_q.ctrl};
                    `TF_REG_LEVELS: s_d.prdata = {28'h0, s_q.levels};
                    `TF_REG_ENABLE: s_d.prdata = {22'h0, s_q.enable};
                    `TF_REG_STATUS: s_d.prdata = {20'h0, 2'(s_q.flowState),
                        s_q.skipCycleCounter, s_q.levelPtr, s_q.storeOn,
                        s_q.triggered, s_q.firstDone, s_q.extSeen};
                    default:
                        if (cfgOk)
                            s_d.prdata = {12'h0, s_q.cfg[widx]};
                        else
                            s_d.pslverr = 1'b1;
                endcase
            end
        end

        // Flow engines run only while armed; disarming parks them
        if (!s_q.ctrl[`TF_CTRL_ARM])
        begin
            s_d.levelPtr         = 4'h0;
            s_d.extSeen          = 1'b0;
            s_d.firstDone        = 1'b0;
            s_d.triggered        = 1'b0;
            s_d.flowState        = trigger_flow_pkg::FirstFlowState;
            s_d.skipCycleCounter = 2'h0;
            s_d.storeOn          = 1'b1;
        end
        else if (!s_q.ctrl[`TF_CTRL_MODE])
        begin
            s_d.storeOn = 1'b1;
            if (s_q.ctrl[`TF_CTRL_EXTEN] && !s_q.extSeen)
                s_d.extSeen = s_q.extLevel;
            else if (s_q.firstDone && s_q.ctrl[`TF_CTRL_SEGM])
            begin
                if (lastHit)
                begin
                    s_d.trigOut  = 1'b1;
                    s_d.segPulse = 1'b1;
                end
            end
            else if (!s_q.triggered && lastIdx != 4'hf)
            begin
                if (!s_q.enable[s_q.levelPtr]
                    || s_q.levelPtr >= s_q.levels)
                    s_d.levelPtr = s_q.levelPtr + 4'h1;
                else if (lvlHit)
                begin
                    if (s_q.levelPtr == lastIdx)
                    begin
                        s_d.trigOut   = 1'b1;
                        s_d.segPulse  = s_q.ctrl[`TF_CTRL_SEGM];
                        s_d.firstDone = 1'b1;
                        s_d.triggered = ~s_q.ctrl[`TF_CTRL_SEGM];
                    end
                    else
                        s_d.levelPtr = s_q.levelPtr + 4'h1;
                end
            end
        end
        else
        begin
            // Condition one is level 0 of the configuration table
            case (s_q.flowState)
                trigger_flow_pkg::FirstFlowState:
                begin
                    s_d.storeOn = 1'b1;
                    if (condHit(s_q.cfg[0], probeData, s_q.prevProbe)
                        && s_q.enable[0])
                    begin
                        s_d.storeOn   = 1'b0;
                        s_d.flowState = trigger_flow_pkg::SecondFlowState;
                    end
                end
                trigger_flow_pkg::SecondFlowState:
                begin
                    if (s_q.skipCycleCounter < `TF_SKIP_COUNT)
                        s_d.skipCycleCounter = s_q.skipCycleCounter + 2'h1;
                    else
                    begin
                        s_d.storeOn  = 1'b1;
                        s_d.trigOut  = 1'b1;
                        s_d.segPulse = s_q.ctrl[`TF_CTRL_SEGM];
                        s_d.skipCycleCounter = 2'h0;
                        s_d.flowState = s_q.ctrl[`TF_CTRL_SEGM]
                            ? trigger_flow_pkg::FirstFlowState
                            : trigger_flow_pkg::FlowDone;
                    end
                end
                trigger_flow_pkg::FlowDone: s_d.storeOn = 1'b1;
                default: s_d.flowState = trigger_flow_pkg::FirstFlowState;
            endcase
        end

        // Output word is replaced only once the buffer has taken it
        if (capReady || !s_q.capValid)
        begin
            s_d.capValid   = fifoOutValid;
            s_d.capSample  = fifoOut.sample;
            s_d.capStoreEn = fifoOut.storeEn & fifoOutValid;
            s_d.capTrigger = fifoOut.trigger & fifoOutValid;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s_q            <= '0;
            s_q.ctrl       <= `TF_CTRL_RST;
            s_q.levels     <= `TF_LEVELS_RST;
            s_q.enable     <= `TF_ENABLE_RST;
            s_q.storeOn    <= 1'b1;
            s_q.flowState  <= trigger_flow_pkg::FirstFlowState;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Sample path
    // ************************************************************
    // A sample is offered every armed cycle; while the buffer stalls and the
    // FIFO is full, samples are dropped rather than stalling the probe
    assign fifoIn.sample  = s_q.prevProbe;
    assign fifoIn.storeEn = s_q.storeOn;
    assign fifoIn.trigger = s_q.trigOut;

    sample_fifo #(
        .WIDTH ($bits(trigger_flow_pkg::capture_s)),
        .DEPTH (`TF_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .inValid  (s_q.ctrl[`TF_CTRL_ARM]),
        .inReady  (),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (capReady | ~s_q.capValid),
        .outData  (fifoOut)
    );

    assign prdata       = s_q.prdata;
    assign pready       = s_q.pready;
    assign pslverr      = s_q.pslverr;
    assign capValid     = s_q.capValid;
    assign capSample    = s_q.capSample;
    assign capStoreEn   = s_q.capStoreEn;
    assign capTrigger   = s_q.capTrigger;
    assign segmentStart = s_q.segPulse;

endmodule : trigger_flow_sequencer

`default_nettype wire

// *** tb/trigger_flow_checker.sv ***
`timescale 1ns/1ns
`default_nettype none

module trigger_flow_checker (
    // Clock and restart reset
    input wire logic        sys_clk,
    input wire logic        srst,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Capture buffer side
    input wire logic        capValid,
    input wire logic        capStoreEn,
    input wire logic        capTrigger,
    input wire logic        segmentStart
);
    // ****************************************************
    // Bus answer and capture side relations
    // ****************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    error_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    status_ro_a: assert property (psel && penable && !pready && pwrite
        && paddr == 12'h00c |=> pslverr)
        else $error("write to status not refused");
    unmapped_err_a: assert property (psel && penable && !pready
        && paddr == 12'h100 |=> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && penable && !pready
        && paddr == 12'h000 |=> !pslverr)
        else $error("control access refused");
    restart_clear_a: assert property ($fell(srst) |-> !capValid
        && !capTrigger && !segmentStart && !capStoreEn)
        else $error("outputs not cleared by restart");
    trig_stored_a: assert property (capTrigger |-> capValid
        && capStoreEn)
        else $error("trigger marker on an unstored word");
endmodule : trigger_flow_checker

bind trigger_flow_sequencer trigger_flow_checker u_chk (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .capValid(capValid), .capStoreEn(capStoreEn),
    .capTrigger(capTrigger), .segmentStart(segmentStart));

`default_nettype wire

// *** tb/capture_buffer_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module capture_buffer_model (
    // Clock
    input wire logic       sys_clk,
    // Buffer port
    input wire logic       capValid,
    output logic           capReady,
    input wire logic [7:0] capSample,
    input wire logic       capStoreEn,
    input wire logic       capTrigger,
    input wire logic       segmentStart,
    // Stall request from the bench
    input wire logic       stall
);
    // ****************************************************
    // Records what the buffer memory would keep
    // ****************************************************
    int trigQ[$];
    int storeQ[$];
    int segCount;
    int nWords;

    assign capReady = !stall;

    always @(posedge sys_clk)
    begin
        if (capValid && capReady)
        begin
            nWords++;
            if (capStoreEn)
                storeQ.push_back(capSample);
            if (capTrigger)
                trigQ.push_back(capSample);
        end
        if (segmentStart)
            segCount++;
    end
endmodule : capture_buffer_model

`default_nettype wire

// *** tb/test_trigger_flow_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none

module test_trigger_flow_sequencer;
    logic        sys_clk, srst, psel, penable, pwrite, extTrigIn, stall;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  probeData, capSample;
    logic        pready, pslverr, err, capValid, capReady;
    logic        capStoreEn, capTrigger, segmentStart;
    int          n_fail, n_tests, cycles, seed, i, v;
    int          kd[3], op[3], vl[3], mk[3];
    int          nLvl, lvlEn, seg, useExt, mPtr, mDone, expQ[$];
    int          seqV[9] = '{8'hf8, 8'h0c, 8'h11, 8'h0c, 8'hf5, 8'h0e,
                             8'h11, 8'hf5, 8'h0e};

    trigger_flow_sequencer DUT (.sys_clk(sys_clk), .srst(srst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .probeData(probeData), .extTrigIn(extTrigIn),
        .capValid(capValid), .capReady(capReady), .capSample(capSample),
        .capStoreEn(capStoreEn), .capTrigger(capTrigger),
        .segmentStart(segmentStart));
    capture_buffer_model u_buf (.sys_clk(sys_clk), .capValid(capValid),
        .capReady(capReady), .capSample(capSample),
        .capStoreEn(capStoreEn), .capTrigger(capTrigger),
        .segmentStart(segmentStart), .stall(stall));

    // ****************************************************
    // Clock, watchdog and shared tasks
    // ****************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        n_tests++;
        if (exp !== got)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Request held until pready is sampled; a spare edge follows release
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic eErr);
        int k;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 40);
        if (k >= 40)
            n_fail++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
        check("slverr", eErr, err);
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 1'b0);
        check($sformatf("register %h", a), e, rd);
    endtask : rdchk

    task automatic lvl(input int n, input int k, input int o,
                       input int val, input int m);
        kd[n] = k;
        op[n] = o;
        vl[n] = val;
        mk[n] = m;
        apb(1'b1, 12'h040 + 12'(4 * n),
            {12'h0, o[1:0], k[1:0], val[7:0], m[7:0]}, 1'b0);
    endtask : lvl

    function automatic bit hit(input int n, input int x);
        x = x & mk[n];
        if (kd[n] == 0)
            return x == (vl[n] & mk[n]);
        if (kd[n] == 1)
            return op[n] == 0 ? x == vl[n] : op[n] == 1 ? x > vl[n] :
                   op[n] == 2 ? x < vl[n] : x != vl[n];
        return op[n] == 0 ? x == mk[n] : op[n] == 1 ? x != 0 : ^x;
    endfunction : hit

    // Model steps once per probe value; gap values never match a level
    task automatic send(input int x, input bit rs);
        probeData <= x[7:0];
        @(posedge sys_clk);
        if (!mDone && (!useExt || extTrigIn))
        begin
            while (mPtr < nLvl - 1 && !lvlEn[mPtr])
                mPtr++;
            if (hit(mPtr, x) && mPtr == nLvl - 1)
            begin
                expQ.push_back(x);
                mDone = !seg;
            end
            else if (hit(mPtr, x))
                mPtr++;
        end
        repeat (3)
        begin
            probeData <= 8'($random(seed) & 3);
            stall <= rs && ($random(seed) & 3) == 0;
            @(posedge sys_clk);
        end
        stall <= 1'b0;
    endtask : send

    task automatic finish_test(input string name);
        repeat (12) @(posedge sys_clk);
        check("trigger count", expQ.size(), u_buf.trigQ.size());
        foreach (expQ[j])
            if (j < u_buf.trigQ.size())
                check("trigger sample", expQ[j], u_buf.trigQ[j]);
        if (seg)
            check("segment starts", expQ.size(), u_buf.segCount);
        apb(1'b1, 12'h000, 32'h0, 1'b0);
        extTrigIn <= 1'b0;
        expQ.delete();
        u_buf.trigQ.delete();
        u_buf.storeQ.delete();
        u_buf.segCount = 0;
        $display("Test %s done", name);
    endtask : finish_test

    task automatic run_seq(input int ctrl, input int en, input int extAt);
        nLvl = 3;
        lvlEn = en;
        seg = ctrl[1];
        useExt = ctrl[2];
        mPtr = 0;
        mDone = 0;
        apb(1'b1, 12'h008, en, 1'b0);
        apb(1'b1, 12'h000, ctrl, 1'b0);
        for (i = 0; i < 9; i++)
        begin
            if (i == extAt)
            begin
                extTrigIn <= 1'b1;
                repeat (6) @(posedge sys_clk);
            end
            send(seqV[i], i < 2);
        end
        finish_test($sformatf("sequential %h", ctrl));
    endtask : run_seq

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial
    begin
        seed = 19;
        {srst, psel, penable, pwrite, extTrigIn, stall} = 6'h20;
        {paddr, pwdata, probeData} = '0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rdchk(12'h000, 32'h0);
        rdchk(12'h004, 32'h1);
        rdchk(12'h008, 32'h3ff);
        apb(1'b0, 12'h100, 32'h0, 1'b1);
        apb(1'b1, 12'h00c, 32'h5, 1'b1);
        apb(1'b1, 12'h004, 32'hf, 1'b0);
        rdchk(12'h004, 32'ha);
        $display("Test registers done");
        apb(1'b1, 12'h004, 32'h3, 1'b0);
        lvl(0, 0, 0, 8'h11, 8'hff);
        lvl(1, 1, 1, 8'hf0, 8'hff);
        lvl(2, 2, 0, 8'h00, 8'h0c);
        run_seq(8, 7, 99);
        run_seq(8, 5, 99);
        run_seq(10, 7, 99);
        run_seq(12, 7, 6);
        apb(1'b1, 12'h000, 32'h8, 1'b0);
        stall <= 1'b1;
        repeat (2) @(posedge sys_clk);
        u_buf.nWords = 0;
        repeat (8) @(posedge sys_clk);
        apb(1'b1, 12'h000, 32'h0, 1'b0);
        stall <= 1'b0;
        repeat (12) @(posedge sys_clk);
        check("drained words", 5, u_buf.nWords);
        $display("Test buffer stall done");
        for (seg = 0; seg < 2; seg++)
        begin
            lvl(0, 0, 0, 8'h25, 8'hff);
            apb(1'b1, 12'h008, 32'h1, 1'b0);
            apb(1'b1, 12'h000, 9 + 2 * seg, 1'b0);
            for (v = 8'h20; v < 8'h30; v++)
            begin
                probeData <= v[7:0];
                @(posedge sys_clk);
            end
            expQ.push_back(8'h29);
            repeat (12) @(posedge sys_clk);
            foreach (u_buf.storeQ[j])
                check("skipped", 0, u_buf.storeQ[j] inside {[38:40]});
            check("restart", 1, 8'h29 inside {u_buf.storeQ});
            finish_test("state flow");
        end
        apb(1'b1, 12'h000, 32'h9, 1'b0);
        probeData <= 8'h25;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rdchk(12'h00c, 32'h8);
        rdchk(12'h000, 32'h0);
        $display("Test restart done");
        end_sim();
    end
endmodule : test_trigger_flow_sequencer

`default_nettype wire
